// [rtl/gpio_bidir_port.sv]
// One 8-bit bidirectional port: output latch, direction and pin drive.
// Assumes pin inputs synchronous to clk; latch is not reset by design.
`timescale 1ns/1ps
`default_nettype none
module gpio_bidir_port
   import gpio_key_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register writes
   input wire logic wrData,
   input wire logic wrDir,
   input wire logic [7:0] wdata,
   // Forced inputs
   input wire logic [7:0] forceIn,
   // Pins
   input wire logic [7:0] pinIn,
   output logic [7:0] pinOut,
   output logic [7:0] pinOe,
   // State
   output logic [7:0] readVal,
   output logic [7:0] dirVal,
   output logic [7:0] pinSample
);
   logic [7:0] latch_ff;
   logic [7:0] dir_ff;
   logic [7:0] pinOut_ff;
   logic [7:0] pinOe_ff;
   logic [7:0] sample_ff;
   logic [7:0] nxt_oe;

   // Output latch, untouched by reset
   always_ff @(posedge clk) begin
      if (wrData) begin
         latch_ff <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dir_ff <= DIR_RESET;
      end else if (wrDir) begin
         dir_ff <= wdata;
      end
   end

   assign nxt_oe = dir_ff & ~forceIn;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinOe_ff <= DIR_RESET;
         pinOut_ff <= 8'h00;
         sample_ff <= SAMPLE_RESET;
      end else begin
         pinOe_ff <= nxt_oe;
         pinOut_ff <= latch_ff;
         sample_ff <= pinIn;
      end
   end

   assign pinOut = pinOut_ff;
   assign pinOe = pinOe_ff;
   assign dirVal = dir_ff;
   assign pinSample = sample_ff;
   assign readVal = (nxt_oe & latch_ff) | (~nxt_oe & sample_ff);
endmodule // gpio_bidir_port
`default_nettype wire

// [rtl/gpio_key_pkg.sv]
// Constants for the GPIO port block with keyboard wakeup.
// Assumes a 32-bit APB slave with one aligned word per register.
package gpio_key_pkg;
   // Register indices as printed; byte address is index times four
   localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
   localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
   localparam logic [7:0] IDX_PORT_C_DATA = 8'h02;
   localparam logic [7:0] IDX_INPUT_PORT_DATA = 8'h03;
   localparam logic [7:0] IDX_PORT_A_DIR = 8'h04;
   localparam logic [7:0] IDX_PORT_B_DIR = 8'h05;
   localparam logic [7:0] IDX_PORT_C_DIR = 8'h06;
   localparam logic [7:0] IDX_FUNC_SEL = 8'h07;
   localparam logic [7:0] IDX_DISP_KEY_CTRL = 8'h1E;
   localparam logic [7:0] IDX_KEY_MASK = 8'h20;
   localparam int ADDR_W = 10;
   // Display/keyboard control fields
   localparam int STATUS_FLAG_BIT = 7;
   localparam int KEY_ENABLE_BIT = 6;
   // Function select bit with no alternate function
   localparam int NO_ALT_BIT = 3;
   localparam logic [7:0] FUNC_SEL_WMASK = 8'hF7;
   // Reset values
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
   localparam logic [7:0] DISP_KEY_RESET = 8'h00;
   localparam logic [7:0] KEY_MASK_RESET = 8'h00;
   localparam logic [7:0] SAMPLE_RESET = 8'hFF;
endpackage

// [rtl/gpio_ports_with_key_wakeup.sv]
// Three bidirectional ports, one input-only port, keyboard wakeup logic.
// Assumes an APB master on clk; pins synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_with_key_wakeup
   import gpio_key_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port A pins
   input wire logic [7:0] portAIn,
   output logic [7:0] portAOut,
   output logic [7:0] portAOe,
   // Port B pins
   input wire logic [7:0] portBIn,
   output logic [7:0] portBOut,
   output logic [7:0] portBOe,
   // Port C pins with keyboard
   input wire logic [7:0] portCIn,
   output logic [7:0] portCOut,
   output logic [7:0] portCOe,
   output logic [7:0] portCPullup,
   // Input-only port
   input wire logic [7:0] inputPortIn,
   output logic [7:0] altFuncSel,
   // Display control bits to the display subsystem
   output logic [5:0] displayCtrl,
   // Core interface
   input wire logic globalIntMask,
   input wire logic externalIrq,
   output logic sharedIrqReq,
   output logic wakeReq
);
   // ****************************************
   // APB decode
   // ****************************************
   logic access;
   logic wrEn;
   logic [7:0] idx;
   logic hit;
   logic [7:0] wbyte;

   assign access = psel && penable;
   assign idx = paddr[ADDR_W-1:2];
   assign wrEn = access && pwrite && pstrb[0] && (paddr[1:0] == 2'b00);
   assign wbyte = pwdata[7:0];

   // ****************************************
   // Register write strobes
   // ****************************************
   logic wrDataA;
   logic wrDirA;
   logic wrDataB;
   logic wrDirB;
   logic wrDataC;
   logic wrDirC;
   logic wrFuncSel;
   logic wrKeyMask;
   logic wrCtrl;

   assign wrDataA = wrEn && (idx == IDX_PORT_A_DATA);
   assign wrDirA = wrEn && (idx == IDX_PORT_A_DIR);
   assign wrDataB = wrEn && (idx == IDX_PORT_B_DATA);
   assign wrDirB = wrEn && (idx == IDX_PORT_B_DIR);
   assign wrDataC = wrEn && (idx == IDX_PORT_C_DATA);
   assign wrDirC = wrEn && (idx == IDX_PORT_C_DIR);
   assign wrFuncSel = wrEn && (idx == IDX_FUNC_SEL);
   assign wrKeyMask = wrEn && (idx == IDX_KEY_MASK);
   assign wrCtrl = wrEn && (idx == IDX_DISP_KEY_CTRL);

   always_comb begin
      hit = 1'b1;
      unique case (idx)
         IDX_PORT_A_DATA, IDX_PORT_B_DATA, IDX_PORT_C_DATA, IDX_INPUT_PORT_DATA,
         IDX_PORT_A_DIR, IDX_PORT_B_DIR, IDX_PORT_C_DIR, IDX_FUNC_SEL,
         IDX_DISP_KEY_CTRL, IDX_KEY_MASK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // ****************************************
   // Keyboard control state
   // ****************************************
   logic [7:0] ctrl_ff;
   logic [7:0] keyMask_ff;
   logic [7:0] funcSel_ff;
   logic keyEnable;
   logic [7:0] forceC;
   logic [7:0] zeroForce;

   assign keyEnable = ctrl_ff[KEY_ENABLE_BIT];
   assign forceC = keyEnable ? keyMask_ff : 8'h00;
   assign zeroForce = 8'h00;

   // ****************************************
   // Bidirectional ports
   // ****************************************
   logic [7:0] rdA, rdB, rdC, dirA, dirB, dirC, sampC;

   gpio_bidir_port u_port_a (
      .clk(clk),
      .resetn(resetn),
      .wrData(wrDataA),
      .wrDir(wrDirA),
      .wdata(wbyte),
      .forceIn(zeroForce),
      .pinIn(portAIn),
      .pinOut(portAOut),
      .pinOe(portAOe),
      .readVal(rdA),
      .dirVal(dirA),
      .pinSample()
   );

   gpio_bidir_port u_port_b (
      .clk(clk),
      .resetn(resetn),
      .wrData(wrDataB),
      .wrDir(wrDirB),
      .wdata(wbyte),
      .forceIn(zeroForce),
      .pinIn(portBIn),
      .pinOut(portBOut),
      .pinOe(portBOe),
      .readVal(rdB),
      .dirVal(dirB),
      .pinSample()
   );

   gpio_bidir_port u_port_c (
      .clk(clk),
      .resetn(resetn),
      .wrData(wrDataC),
      .wrDir(wrDirC),
      .wdata(wbyte),
      .forceIn(forceC),
      .pinIn(portCIn),
      .pinOut(portCOut),
      .pinOe(portCOe),
      .readVal(rdC),
      .dirVal(dirC),
      .pinSample(sampC)
   );

   // ****************************************
   // Pull-ups follow the effective direction
   // ****************************************
   logic [7:0] pullup_ff;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pullup_ff <= 8'hFF;
      end else begin
         pullup_ff <= ~(dirC & ~forceC);
      end
   end

   assign portCPullup = pullup_ff;

   // ****************************************
   // Input-only port and function select
   // ****************************************
   logic [7:0] inSample_ff;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         funcSel_ff <= FUNC_SEL_RESET;
      end else if (wrFuncSel) begin
         funcSel_ff <= wbyte & FUNC_SEL_WMASK;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inSample_ff <= 8'h00;
      end else begin
         inSample_ff <= inputPortIn;
      end
   end

   assign altFuncSel = funcSel_ff;

   // ****************************************
   // Keyboard mask and control register
   // ****************************************
   logic [7:0] prevC_ff;
   logic keyEdge;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prevC_ff <= SAMPLE_RESET;
      end else begin
         prevC_ff <= sampC;
      end
   end

   // Falling edge on an armed pin
   assign keyEdge = keyEnable && |(keyMask_ff & prevC_ff & ~sampC);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         keyMask_ff <= KEY_MASK_RESET;
      end else if (wrKeyMask) begin
         keyMask_ff <= wbyte;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= DISP_KEY_RESET;
      end else begin
         if (wrCtrl) begin
            ctrl_ff[6:0] <= wbyte[6:0];
            // Flag clears on written zero only
            if (!wbyte[STATUS_FLAG_BIT]) begin
               ctrl_ff[STATUS_FLAG_BIT] <= 1'b0;
            end
         end
         // Set wins over a simultaneous clear
         if (keyEdge) begin
            ctrl_ff[STATUS_FLAG_BIT] <= 1'b1;
         end
      end
   end

   assign displayCtrl = ctrl_ff[5:0];

   // ****************************************
   // Interrupt request and wakeup
   // ****************************************
   logic keyReq;
   logic irq_ff;
   logic wake_ff;

   assign keyReq = ctrl_ff[STATUS_FLAG_BIT] && keyEnable;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_ff <= (keyReq || externalIrq) && !globalIntMask;
         wake_ff <= keyReq || externalIrq;
      end
   end

   assign sharedIrqReq = irq_ff;
   assign wakeReq = wake_ff;

   // ****************************************
   // Read data and response
   // ****************************************
   logic [7:0] rbyte;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   always_comb begin
      rbyte = 8'h00;
      unique case (idx)
         IDX_PORT_A_DATA: rbyte = rdA;
         IDX_PORT_B_DATA: rbyte = rdB;
         IDX_PORT_C_DATA: rbyte = rdC;
         IDX_INPUT_PORT_DATA: rbyte = inSample_ff;
         IDX_PORT_A_DIR: rbyte = dirA;
         IDX_PORT_B_DIR: rbyte = dirB;
         IDX_PORT_C_DIR: rbyte = dirC;
         IDX_FUNC_SEL: rbyte = funcSel_ff;
         IDX_DISP_KEY_CTRL: rbyte = ctrl_ff;
         IDX_KEY_MASK: rbyte = keyMask_ff;
         default: rbyte = 8'h00;
      endcase
   end

   // No wait state: answer in first access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= psel && !penable;
         pslverr_ff <= psel && !penable && !hit;
         prdata_ff <= {24'h000000, rbyte};
      end
   end

   // Write effect gated to the completing edge
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;
endmodule // gpio_ports_with_key_wakeup
`default_nettype wire

// [tb/gpio_key_asserts.sv]
// Checker for the GPIO port block, bound to its top module.
// Assumes every output is registered on clk.
`timescale 1ns/1ps
`default_nettype none
module gpio_key_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Bus
   input wire logic pwrite,
   input wire logic pready,
   // Pins
   input wire logic [7:0] portAOe,
   input wire logic [7:0] portCOe,
   input wire logic [7:0] portCPullup,
   input wire logic [7:0] altFuncSel,
   // Core
   input wire logic globalIntMask,
   input wire logic externalIrq,
   input wire logic sharedIrqReq,
   input wire logic wakeReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_dir_reset: assert property (
      $rose(resetn) |-> portAOe == 8'h00 && portCOe == 8'h00) else $error("oe after reset");
   a_sel_reset: assert property (
      $rose(resetn) |-> altFuncSel == 8'h00) else $error("select after reset");
   a_pull_input: assert property (
      (~portCOe & ~portCPullup) == 8'h00) else $error("input without pull-up");
   a_sel_bit3: assert property (
      altFuncSel[3] == 1'b0) else $error("select bit 3 set");
   a_oe_by_write: assert property (
      !$stable(portAOe) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
      else $error("oe changed without write");
   a_irq_masked: assert property (
      globalIntMask |=> !sharedIrqReq) else $error("request while masked");
   a_ext_shared: assert property (
      !globalIntMask && externalIrq |=> sharedIrqReq) else $error("external not shared");
   a_wake_irq: assert property (
      sharedIrqReq |-> wakeReq) else $error("request without wake");
endmodule // gpio_key_asserts

bind gpio_ports_with_key_wakeup gpio_key_asserts u_asserts (.clk(clk), .resetn(resetn),
   .pwrite(pwrite), .pready(pready), .portAOe(portAOe), .portCOe(portCOe),
   .portCPullup(portCPullup), .altFuncSel(altFuncSel), .globalIntMask(globalIntMask),
   .externalIrq(externalIrq), .sharedIrqReq(sharedIrqReq), .wakeReq(wakeReq));
`default_nettype wire

// [tb/gpio_ports_with_key_wakeup_tb_top.sv]
// Testbench for the GPIO port block with keyboard wakeup.
// Assumes the APB slave answers with pready; board model on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin errCount++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module gpio_ports_with_key_wakeup_tb_top;
   import gpio_key_pkg::*;
   typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} row_t;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdVal;
   logic pready, pslverr, rdErr, globalIntMask = 1'b0, externalIrq = 1'b0;
   logic [7:0] keyDown = 8'h00, portAIn, portBIn, portCIn, portAOut, portAOe, portBOut;
   logic [7:0] portBOe, portCOut, portCOe, portCPullup, altFuncSel;
   logic sharedIrqReq, wakeReq;
   int errCount = 0, numChecks = 0, cycles = 0;
   // Data rows precede direction rows for ports A and C: latch loaded before driving
   row_t rows[11] = '{'{IDX_PORT_A_DATA, 8'h5A, 8'h96}, '{IDX_PORT_A_DIR, 8'hFF, 8'hFF},
      '{IDX_PORT_A_DATA, 8'h5A, 8'h5A}, '{IDX_PORT_B_DIR, 8'h0F, 8'h0F},
      '{IDX_PORT_B_DATA, 8'h3C, 8'hCC}, '{IDX_INPUT_PORT_DATA, 8'h00, 8'hA5},
      '{IDX_FUNC_SEL, 8'hFF, 8'hF7}, '{IDX_PORT_C_DATA, 8'hFF, 8'hFF},
      '{IDX_PORT_C_DIR, 8'hFF, 8'hFF}, '{IDX_KEY_MASK, 8'h0F, 8'h0F},
      '{IDX_DISP_KEY_CTRL, 8'h40, 8'h40}};
   always #20 clk = ~clk;
   gpio_ports_with_key_wakeup u_dut (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .portAIn(portAIn),
      .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut),
      .portBOe(portBOe), .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe),
      .portCPullup(portCPullup), .inputPortIn(8'hA5), .altFuncSel(altFuncSel),
      .displayCtrl(), .globalIntMask(globalIntMask), .externalIrq(externalIrq),
      .sharedIrqReq(sharedIrqReq), .wakeReq(wakeReq));
   pin_board_model u_board (.portAOut(portAOut), .portAOe(portAOe), .portBOut(portBOut),
      .portBOe(portBOe), .portCOut(portCOut), .portCOe(portCOe), .portCPullup(portCPullup),
      .boardA(8'h96), .boardB(8'hC3), .keyDown(keyDown), .portAIn(portAIn),
      .portBIn(portBIn), .portCIn(portCIn));
   task automatic stopTest();
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
      apb(1'b0, idx, 8'h00);
      `CHK("register", {24'h000000, ex}, rdVal)
   endtask
   task automatic resetVals();
      foreach (rows[i]) if (rows[i].idx > 8'h03) rd(rows[i].idx, 8'h00);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errCount++;
         stopTest();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      resetVals();
      externalIrq <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("shared", 1'b1, sharedIrqReq)
      externalIrq <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].idx, rows[i].wd);
         rd(rows[i].idx, rows[i].ex);
      end
      `CHK("outA", 8'h5A, portAOut)
      `CHK("outB", 8'h3C, portBOut)
      `CHK("select", 8'hF7, altFuncSel)
      `CHK("oeC", 8'hF0, portCOe)
      `CHK("pullC", 8'h0F, portCPullup)
      keyDown <= 8'h01;
      repeat (3) @(posedge clk);
      rd(IDX_DISP_KEY_CTRL, 8'hC0);
      `CHK("irq", 1'b1, sharedIrqReq)
      globalIntMask <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("masked", 1'b0, sharedIrqReq)
      `CHK("wake", 1'b1, wakeReq)
      globalIntMask <= 1'b0;
      apb(1'b1, IDX_DISP_KEY_CTRL, 8'hC0);
      rd(IDX_DISP_KEY_CTRL, 8'hC0);
      apb(1'b1, IDX_DISP_KEY_CTRL, 8'h40);
      rd(IDX_DISP_KEY_CTRL, 8'h40);
      `CHK("irqOff", 1'b0, sharedIrqReq)
      keyDown <= 8'h00;
      repeat (3) @(posedge clk);
      keyDown <= 8'h02;
      repeat (3) @(posedge clk);
      rd(IDX_DISP_KEY_CTRL, 8'hC0);
      rd(8'h1F, 8'h00);
      `CHK("slverr", 1'b1, rdErr)
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      resetVals();
      apb(1'b1, IDX_PORT_A_DIR, 8'hFF);
      repeat (3) @(posedge clk);
      `CHK("latchA", 8'h5A, portAOut)
      stopTest();
   end
endmodule // gpio_ports_with_key_wakeup_tb_top
`default_nettype wire

// [tb/pin_board_model.sv]
// Board around the pins: external levels, keypad switches to ground.
// Assumes driven pins win over the board.
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
   // Design drive
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portAOe,
   input wire logic [7:0] portBOut,
   input wire logic [7:0] portBOe,
   input wire logic [7:0] portCOut,
   input wire logic [7:0] portCOe,
   input wire logic [7:0] portCPullup,
   // Board
   input wire logic [7:0] boardA,
   input wire logic [7:0] boardB,
   input wire logic [7:0] keyDown,
   // Pin levels
   output logic [7:0] portAIn,
   output logic [7:0] portBIn,
   output logic [7:0] portCIn
);
   assign portAIn = (portAOut & portAOe) | (boardA & ~portAOe);
   assign portBIn = (portBOut & portBOe) | (boardB & ~portBOe);
   // Pressed key pulls low, else pull-up
   assign portCIn = (portCOut & portCOe) | (~portCOe & ~keyDown & portCPullup);
endmodule // pin_board_model
`default_nettype wire
